// ### common/special_function_pkg.sv
// Purpose: constants for the special function register bank
// Assumes: 8-bit direct addresses 0x80..0xFF, one byte per register
// Notes: register index in the table equals its position in the packs
//
// Functional notes
// - Reads of unoccupied addresses may return anything; here they read zero.
// - Writes to unoccupied addresses change no register and no state.
// - Only the port 0, 1, 2 and timer control row bases allow single-bit access.
// - Power control at 0x87: baud doubles, voltage reset, irq, clocks, sleep.
// - Timer mode at 0x89: two nibbles of gate, select and two mode bits.
// - Function selects: port1 bits 7:4, port3 bits 7:6, port4 all bits.
// - Converter prescaler byte at 0x95, conversion result byte at 0x96.
// - Converter control: enable bit5, channel 3:2, start bit1, done bit0.
// - Both serial controls share one layout; buffers at 0x99 and 0x9B.
// - Pulse width control at 0xA1; duty bytes at 0xA2 and 0xA3.
package special_function_pkg;

    localparam int NUM_REGS = 26;
    localparam int IDX_W = 5;

    // Direct addresses; the Avalon word address carries the same value
    localparam logic [7:0] OFF_PORT0 = 8'h80;
    localparam logic [7:0] OFF_STACK = 8'h81;
    localparam logic [7:0] OFF_DPTR_LOW = 8'h82;
    localparam logic [7:0] OFF_DPTR_HIGH = 8'h83;
    localparam logic [7:0] OFF_POWER = 8'h87;
    localparam logic [7:0] OFF_TIMER_CTRL = 8'h88;
    localparam logic [7:0] OFF_TIMER_MODE = 8'h89;
    localparam logic [7:0] OFF_T0_LOW = 8'h8a;
    localparam logic [7:0] OFF_T1_LOW = 8'h8b;
    localparam logic [7:0] OFF_T0_HIGH = 8'h8c;
    localparam logic [7:0] OFF_T1_HIGH = 8'h8d;
    localparam logic [7:0] OFF_PORT1 = 8'h90;
    localparam logic [7:0] OFF_P1_SELECT = 8'h91;
    localparam logic [7:0] OFF_P3_SELECT = 8'h93;
    localparam logic [7:0] OFF_P4_SELECT = 8'h94;
    localparam logic [7:0] OFF_CONV_PRESCALE = 8'h95;
    localparam logic [7:0] OFF_CONV_RESULT = 8'h96;
    localparam logic [7:0] OFF_CONV_CTRL = 8'h97;
    localparam logic [7:0] OFF_SER1_CTRL = 8'h98;
    localparam logic [7:0] OFF_SER1_BUF = 8'h99;
    localparam logic [7:0] OFF_SER2_CTRL = 8'h9a;
    localparam logic [7:0] OFF_SER2_BUF = 8'h9b;
    localparam logic [7:0] OFF_PORT2 = 8'ha0;
    localparam logic [7:0] OFF_PWM_CTRL = 8'ha1;
    localparam logic [7:0] OFF_PWM_DUTY0 = 8'ha2;
    localparam logic [7:0] OFF_PWM_DUTY1 = 8'ha3;

    // Table order: entry 0 is the rightmost element
    localparam logic [NUM_REGS-1:0][7:0] REG_OFFSETS = {
        OFF_PWM_DUTY1, OFF_PWM_DUTY0, OFF_PWM_CTRL, OFF_PORT2,
        OFF_SER2_BUF, OFF_SER2_CTRL, OFF_SER1_BUF, OFF_SER1_CTRL,
        OFF_CONV_CTRL, OFF_CONV_RESULT, OFF_CONV_PRESCALE, OFF_P4_SELECT,
        OFF_P3_SELECT, OFF_P1_SELECT, OFF_PORT1, OFF_T1_HIGH,
        OFF_T0_HIGH, OFF_T1_LOW, OFF_T0_LOW, OFF_TIMER_MODE,
        OFF_TIMER_CTRL, OFF_POWER, OFF_DPTR_HIGH, OFF_DPTR_LOW,
        OFF_STACK, OFF_PORT0};

    // Indices into the table
    localparam int IDX_PORT0 = 0;
    localparam int IDX_STACK = 1;
    localparam int IDX_DPTR_LOW = 2;
    localparam int IDX_DPTR_HIGH = 3;
    localparam int IDX_POWER = 4;
    localparam int IDX_TIMER_CTRL = 5;
    localparam int IDX_TIMER_MODE = 6;
    localparam int IDX_PORT1 = 11;
    localparam int IDX_P1_SELECT = 12;
    localparam int IDX_P3_SELECT = 13;
    localparam int IDX_P4_SELECT = 14;
    localparam int IDX_CONV_PRESCALE = 15;
    localparam int IDX_CONV_RESULT = 16;
    localparam int IDX_CONV_CTRL = 17;
    localparam int IDX_SER1_CTRL = 18;
    localparam int IDX_SER1_BUF = 19;
    localparam int IDX_SER2_CTRL = 20;
    localparam int IDX_SER2_BUF = 21;
    localparam int IDX_PORT2 = 22;
    localparam int IDX_PWM_CTRL = 23;
    localparam int IDX_PWM_DUTY0 = 24;
    localparam int IDX_PWM_DUTY1 = 25;

    // Reset values
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [7:0] STACK_RESET = 8'h07;
    localparam logic [7:0] OTHER_RESET = 8'h00;

    // Field positions
    localparam int TC_T1_OVF = 7;
    localparam int TC_T0_OVF = 5;
    localparam int TC_EXT1_FLAG = 3;
    localparam int TC_EXT0_FLAG = 1;
    localparam int CC_DONE = 0;
    localparam int SC_TX_DONE = 1;
    localparam int SC_RX_DONE = 0;
    localparam int SC_NINTH_RX = 2;

    // Row bases that allow single-bit access, upper five address bits
    localparam logic [4:0] ROW_PORT0 = 5'h10;
    localparam logic [4:0] ROW_TIMER_CTRL = 5'h11;
    localparam logic [4:0] ROW_PORT1 = 5'h12;
    localparam logic [4:0] ROW_PORT2 = 5'h14;

    // Avalon word address bit that selects the single-bit window
    localparam int BIT_SPACE_POS = 8;

endpackage

// ### hw/mcu_special_function_register_bank.sv
// Purpose: special function register bank at direct addresses 0x80..0xA3
// Assumes: Avalon-MM slave, word addressed, one register per 32-bit word
// Notes: address bit 8 selects a single-bit window over the row bases
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module mcu_special_function_register_bank (
    input wire logic mclk,                   // 25 MHz system clock
    input wire logic rst_n,                  // Synchronous reset, active low
    input wire logic [8:0] avs_address,      // Word address, see notes
    input wire logic avs_read,               // Read request
    input wire logic avs_write,              // Write request
    input wire logic [3:0] avs_byteenable,   // Only lane 0 carries data
    input wire logic [31:0] avs_writedata,   // Write data, low byte used
    output logic [31:0] avs_readdata,        // Registered read data
    output logic avs_waitrequest,            // Stall for read fetch
    input wire logic timer0Overflow,         // Pulse from timer 0
    input wire logic timer1Overflow,         // Pulse from timer 1
    input wire logic extInt0Event,           // Pulse from edge detector 0
    input wire logic extInt1Event,           // Pulse from edge detector 1
    input wire logic convDone,               // Conversion finished pulse
    input wire logic [7:0] convResult,       // Result with convDone
    input wire logic serial1TxDone,          // First port sent a byte
    input wire logic serial1RxDone,          // First port got a byte
    input wire logic [8:0] serial1RxData,    // Ninth bit and byte
    input wire logic serial2TxDone,          // Second port sent a byte
    input wire logic serial2RxDone,          // Second port got a byte
    input wire logic [8:0] serial2RxData,    // Ninth bit and byte
    output logic [7:0] port0Latch,           // Port 0 output latch
    output logic [7:0] port1Latch,           // Port 1 output latch
    output logic [7:0] port2Latch,           // Port 2 output latch
    output logic [7:0] stackPointer,         // Stack pointer to the core
    output logic [15:0] dataPointer,         // Data pointer to the core
    output logic [7:0] powerControl,         // Power and clock bits
    output logic [7:0] timerControl,         // Timer run and flag bits
    output logic [7:0] timerMode,            // Timer modes
    output logic [3:0] port1FunctionSelect,  // Port 1 pins 7:4
    output logic [1:0] port3FunctionSelect,  // Port 3 pins 7:6
    output logic [7:0] port4FunctionSelect,  // Port 4 pins
    output logic [7:0] converterPrescaler,   // Converter clock divide
    output logic [7:0] converterControl,     // Enable, channel, start
    output logic [7:0] serial1Control,       // First port control
    output logic [7:0] serial1TxData,        // First port buffer
    output logic [7:0] serial2Control,       // Second port control
    output logic [7:0] serial2TxData,        // Second port buffer
    output logic [7:0] pulseWidthControl,    // Load, polarity, enable
    output logic [7:0] pulseWidthDuty0,      // Duty of output 0
    output logic [7:0] pulseWidthDuty1       // Duty of output 1
);

    localparam int NR = special_function_pkg::NUM_REGS;
    localparam int IW = special_function_pkg::IDX_W;

    typedef struct packed {
        logic [NR-1:0][7:0] regs;
        logic rdValid;
        logic [7:0] rdData;
    } state_t;

    state_t q;
    state_t d;
    state_t resetState;

    logic directHit;
    logic [IW-1:0] directIdx;
    logic bitHit;
    logic [IW-1:0] rowIdx;
    logic bitRowOk;
    logic [7:0] directAddr;
    logic [7:0] rowAddr;
    logic inBitSpace;
    logic wrStrobe;

    // Linear search of the offset table; small enough to stay flat
    function automatic logic [IW:0] findReg(input logic [7:0] addr);
        logic [IW:0] res;
        res = '0;
        for (int i = 0; i < NR; i++) begin
            if (special_function_pkg::REG_OFFSETS[i] == addr) begin
                res = {1'b1, IW'(i)};
            end
        end
        return res;
    endfunction

    // Reset image, ports high and stack pointer at seven
    always_comb begin
        resetState = '0;
        for (int i = 0; i < NR; i++) begin
            resetState.regs[i] = special_function_pkg::OTHER_RESET;
        end
        resetState.regs[special_function_pkg::IDX_PORT0] =
            special_function_pkg::PORT_RESET;
        resetState.regs[special_function_pkg::IDX_PORT1] =
            special_function_pkg::PORT_RESET;
        resetState.regs[special_function_pkg::IDX_PORT2] =
            special_function_pkg::PORT_RESET;
        resetState.regs[special_function_pkg::IDX_STACK] =
            special_function_pkg::STACK_RESET;
    end

    // Address decode for byte and single-bit windows
    always_comb begin
        inBitSpace = avs_address[special_function_pkg::BIT_SPACE_POS];
        directAddr = avs_address[7:0];
        rowAddr = {avs_address[7:3], 3'b000};
        {directHit, directIdx} = findReg(directAddr);
        {bitHit, rowIdx} = findReg(rowAddr);
        if (avs_address[7:3] == special_function_pkg::ROW_PORT0) begin
            bitRowOk = 1'b1;
        end else if (avs_address[7:3] ==
                     special_function_pkg::ROW_TIMER_CTRL) begin
            bitRowOk = 1'b1;
        end else if (avs_address[7:3] == special_function_pkg::ROW_PORT1) begin
            bitRowOk = 1'b1;
        end else if (avs_address[7:3] == special_function_pkg::ROW_PORT2) begin
            bitRowOk = 1'b1;
        end else begin
            bitRowOk = 1'b0;
        end
        wrStrobe = avs_write && avs_byteenable[0];
    end

    // Next state: bus read, bus write, then hardware events on top
    always_comb begin
        d = q;
        d.rdValid = 1'b0;
        // One wait cycle per read so read data comes from a flop
        if (avs_read && !q.rdValid) begin
            d.rdValid = 1'b1;
            if (!inBitSpace && directHit) begin
                d.rdData = q.regs[directIdx];
            end else if (inBitSpace && bitHit && bitRowOk) begin
                d.rdData = {7'h00, q.regs[rowIdx][avs_address[2:0]]};
            end else begin
                d.rdData = 8'h00;
            end
        end
        // Unmapped writes fall through and touch nothing
        if (wrStrobe && !inBitSpace && directHit) begin
            d.regs[directIdx] = avs_writedata[7:0];
        end else if (wrStrobe && inBitSpace && bitHit && bitRowOk) begin
            d.regs[rowIdx][avs_address[2:0]] = avs_writedata[0];
        end
        // Hardware sets win over a clearing write in the same cycle
        if (timer1Overflow) begin
            d.regs[special_function_pkg::IDX_TIMER_CTRL]
                [special_function_pkg::TC_T1_OVF] = 1'b1;
        end
        if (timer0Overflow) begin
            d.regs[special_function_pkg::IDX_TIMER_CTRL]
                [special_function_pkg::TC_T0_OVF] = 1'b1;
        end
        if (extInt1Event) begin
            d.regs[special_function_pkg::IDX_TIMER_CTRL]
                [special_function_pkg::TC_EXT1_FLAG] = 1'b1;
        end
        if (extInt0Event) begin
            d.regs[special_function_pkg::IDX_TIMER_CTRL]
                [special_function_pkg::TC_EXT0_FLAG] = 1'b1;
        end
        if (convDone) begin
            d.regs[special_function_pkg::IDX_CONV_RESULT] = convResult;
            d.regs[special_function_pkg::IDX_CONV_CTRL]
                [special_function_pkg::CC_DONE] = 1'b1;
        end
        if (serial1TxDone) begin
            d.regs[special_function_pkg::IDX_SER1_CTRL]
                [special_function_pkg::SC_TX_DONE] = 1'b1;
        end
        if (serial1RxDone) begin
            d.regs[special_function_pkg::IDX_SER1_BUF] =
                serial1RxData[7:0];
            d.regs[special_function_pkg::IDX_SER1_CTRL]
                [special_function_pkg::SC_NINTH_RX] = serial1RxData[8];
            d.regs[special_function_pkg::IDX_SER1_CTRL]
                [special_function_pkg::SC_RX_DONE] = 1'b1;
        end
        if (serial2TxDone) begin
            d.regs[special_function_pkg::IDX_SER2_CTRL]
                [special_function_pkg::SC_TX_DONE] = 1'b1;
        end
        if (serial2RxDone) begin
            d.regs[special_function_pkg::IDX_SER2_BUF] =
                serial2RxData[7:0];
            d.regs[special_function_pkg::IDX_SER2_CTRL]
                [special_function_pkg::SC_NINTH_RX] = serial2RxData[8];
            d.regs[special_function_pkg::IDX_SER2_CTRL]
                [special_function_pkg::SC_RX_DONE] = 1'b1;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= resetState;
        end else begin
            q <= d;
        end
    end

    // Bus answers; waitrequest only holds off the first read cycle
    assign avs_waitrequest = avs_read && !q.rdValid;
    assign avs_readdata = {24'h000000, q.rdData};

    // Register images to the peripherals
    assign port0Latch = q.regs[special_function_pkg::IDX_PORT0];
    assign port1Latch = q.regs[special_function_pkg::IDX_PORT1];
    assign port2Latch = q.regs[special_function_pkg::IDX_PORT2];
    assign stackPointer = q.regs[special_function_pkg::IDX_STACK];
    assign dataPointer = {q.regs[special_function_pkg::IDX_DPTR_HIGH],
                          q.regs[special_function_pkg::IDX_DPTR_LOW]};
    assign powerControl = q.regs[special_function_pkg::IDX_POWER];
    assign timerControl = q.regs[special_function_pkg::IDX_TIMER_CTRL];
    assign timerMode = q.regs[special_function_pkg::IDX_TIMER_MODE];
    // Unused select bits are stored but have no pins behind them
    assign port1FunctionSelect =
        q.regs[special_function_pkg::IDX_P1_SELECT][7:4];
    assign port3FunctionSelect =
        q.regs[special_function_pkg::IDX_P3_SELECT][7:6];
    assign port4FunctionSelect =
        q.regs[special_function_pkg::IDX_P4_SELECT];
    assign converterPrescaler =
        q.regs[special_function_pkg::IDX_CONV_PRESCALE];
    assign converterControl =
        q.regs[special_function_pkg::IDX_CONV_CTRL];
    assign serial1Control = q.regs[special_function_pkg::IDX_SER1_CTRL];
    assign serial1TxData = q.regs[special_function_pkg::IDX_SER1_BUF];
    assign serial2Control = q.regs[special_function_pkg::IDX_SER2_CTRL];
    assign serial2TxData = q.regs[special_function_pkg::IDX_SER2_BUF];
    assign pulseWidthControl =
        q.regs[special_function_pkg::IDX_PWM_CTRL];
    assign pulseWidthDuty0 = q.regs[special_function_pkg::IDX_PWM_DUTY0];
    assign pulseWidthDuty1 = q.regs[special_function_pkg::IDX_PWM_DUTY1];

    // Checks on the bank's own behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic noEvents;
    assign noEvents = !(timer0Overflow || timer1Overflow || extInt0Event ||
                        extInt1Event || convDone || serial1TxDone ||
                        serial1RxDone || serial2TxDone || serial2RxDone);

    unmapped_write_a: assert property (
        (wrStrobe && !inBitSpace && !directHit && noEvents) |=>
            (q.regs == $past(q.regs)))
        else $error("unmapped write changed a register");

    reset_image_a: assert property (disable iff (1'b0)
        (!rst_n) |=> (port0Latch == 8'hff && stackPointer == 8'h07 &&
                      timerMode == 8'h00 && pulseWidthDuty1 == 8'h00))
        else $error("reset values wrong");

    read_stall_a: assert property (
        (avs_read && !q.rdValid) |-> avs_waitrequest ##1
            (!avs_waitrequest || !avs_read))
        else $error("read not answered after one wait cycle");

    read_data_a: assert property (
        (avs_read && !q.rdValid && !inBitSpace && directHit &&
         directAddr == special_function_pkg::OFF_STACK) |=>
            (avs_readdata == {24'h000000, $past(stackPointer)}))
        else $error("stack pointer read returned wrong data");

    stack_write_a: assert property (
        (wrStrobe && !inBitSpace &&
         directAddr == special_function_pkg::OFF_STACK) |=>
            (stackPointer == $past(avs_writedata[7:0])))
        else $error("stack pointer write lost");

    bit_write_a: assert property (
        (wrStrobe && inBitSpace &&
         avs_address[7:3] == special_function_pkg::ROW_PORT1) |=>
            (port1Latch ==
             (($past(port1Latch) & ~(8'h01 << $past(avs_address[2:0]))) |
              ({7'h00, $past(avs_writedata[0])} <<
               $past(avs_address[2:0])))))
        else $error("single-bit write disturbed its neighbours");

    conv_done_a: assert property (
        convDone |=> (converterControl[0] &&
                      q.regs[special_function_pkg::IDX_CONV_RESULT] ==
                      $past(convResult)) [*1])
        else $error("conversion done not recorded");

    overflow_set_a: assert property (
        timer0Overflow |=>
            timerControl[special_function_pkg::TC_T0_OVF])
        else $error("timer 0 overflow flag not set");

    pwm_write_a: assert property (
        (wrStrobe && !inBitSpace &&
         directAddr == special_function_pkg::OFF_PWM_CTRL) |=>
            (pulseWidthControl == $past(avs_writedata[7:0])))
        else $error("pulse width control write lost");

endmodule

`default_nettype wire

// ### sim/core_bus_model.sv
// Purpose: core side of the register bus, issues single byte accesses
// Assumes: Avalon-MM master, slave answers through waitrequest
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module core_bus_model (
    input wire logic mclk,                 // System clock
    output logic [8:0] avs_address,        // Word address
    output logic avs_read,                 // Read request
    output logic avs_write,                // Write request
    output logic [3:0] avs_byteenable,     // Lane enables
    output logic [31:0] avs_writedata,     // Write data
    input wire logic [31:0] avs_readdata,  // Read data
    input wire logic avs_waitrequest       // Slave stall
);
    // Idle bus at time zero
    initial begin
        avs_address = 9'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0;
    end

    // One whole byte access, held until waitrequest is seen low
    task automatic access(input logic wr, input logic [8:0] a,
        input logic [7:0] d, input logic [3:0] be,
        output logic [31:0] q, output bit ok);
        ok = 1'b0;
        q = 32'h0;
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_byteenable <= be;
        avs_writedata <= {24'h0, d};
        // Bounded wait so a stuck slave cannot hang the run
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) begin
                ok = 1'b1;
                q = avs_readdata;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~{24'h0, d};
    endtask
endmodule

`default_nettype wire

// ### sim/tb_top.sv
// Purpose: self-checking bench of the special function register bank
// Assumes: core bus model drives every bus access
// Notes: expectations kept in a shadow table of register values
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic mclk, rst_n, t0Ov, t1Ov, e0, e1, cDone, s1Tx, s1Rx, s2Tx, s2Rx;
    logic [7:0] cRes;
    logic [8:0] s1Data, s2Data, avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] port0Out, port1Out, port2Out, stackOut;
    logic [7:0] pwrC, tmrC, tmrM, p4S, cPre, cCtl;
    logic [7:0] s1C, s1B, s2C, s2B, pwC, pwD0, pwD1;
    logic [15:0] dptr;
    logic [3:0] p1S;
    logic [1:0] p3S;
    logic [7:0] model [special_function_pkg::NUM_REGS];
    int mismatches, num_checks;
    bit ok;

    core_bus_model i_core_bus_model (.mclk(mclk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    mcu_special_function_register_bank i_mcu_special_function_register_bank (
        .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timer0Overflow(t0Ov), .timer1Overflow(t1Ov), .extInt0Event(e0),
        .extInt1Event(e1), .convDone(cDone), .convResult(cRes),
        .serial1TxDone(s1Tx), .serial1RxDone(s1Rx), .serial1RxData(s1Data),
        .serial2TxDone(s2Tx), .serial2RxDone(s2Rx), .serial2RxData(s2Data),
        .port0Latch(port0Out), .port1Latch(port1Out),
        .port2Latch(port2Out), .stackPointer(stackOut),
        .dataPointer(dptr), .powerControl(pwrC),
        .timerControl(tmrC), .timerMode(tmrM), .port1FunctionSelect(p1S),
        .port3FunctionSelect(p3S), .port4FunctionSelect(p4S),
        .converterPrescaler(cPre), .converterControl(cCtl),
        .serial1Control(s1C), .serial1TxData(s1B), .serial2Control(s2C),
        .serial2TxData(s2B), .pulseWidthControl(pwC),
        .pulseWidthDuty0(pwD0), .pulseWidthDuty1(pwD1));

    // Free-running 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A lost answer counts as a mismatch and ends the run
    task bus(input logic wr, input logic [8:0] a, input logic [7:0] d,
        input logic [3:0] be);
        i_core_bus_model.access(wr, a, d, be, q, ok);
        if (!ok) begin
            mismatches++;
            wrap_up();
        end
    endtask

    function automatic int idx(input logic [7:0] off);
        for (int i = 0; i < special_function_pkg::NUM_REGS; i++)
            if (special_function_pkg::REG_OFFSETS[i] === off) return i;
        return -1;
    endfunction

    // Port 1 and port 3 select registers only define their upper bits
    function automatic logic [7:0] rmask(input logic [7:0] off);
        return off == 8'h91 ? 8'hf0 : (off == 8'h93 ? 8'hc0 : 8'hff);
    endfunction

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, {1'b0, a}, d, 4'h1);
        if (idx(a) >= 0) model[idx(a)] = d;
    endtask

    // Read back every register against the shadow table
    task walk;
        logic [7:0] off;
        for (int i = 0; i < special_function_pkg::NUM_REGS; i++) begin
            off = special_function_pkg::REG_OFFSETS[i];
            bus(1'b0, {1'b0, off}, 8'h00, 4'h1);
            check(q & rmask(off), {24'h0, model[i] & rmask(off)});
        end
    endtask

    task do_reset;
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
    endtask

    task t_reset;
        for (int i = 0; i < special_function_pkg::NUM_REGS; i++)
            model[i] = special_function_pkg::OTHER_RESET;
        model[special_function_pkg::IDX_PORT0] = 8'hff;
        model[special_function_pkg::IDX_PORT1] = 8'hff;
        model[special_function_pkg::IDX_PORT2] = 8'hff;
        model[special_function_pkg::IDX_STACK] = 8'h07;
        walk();
        check({port0Out, port1Out, port2Out, stackOut}, 32'hffffff07);
    endtask

    // Distinct byte per offset exposes any swapped or shared decode
    task t_rw;
        for (int i = 0; i < special_function_pkg::NUM_REGS; i++)
            wr(special_function_pkg::REG_OFFSETS[i],
                special_function_pkg::REG_OFFSETS[i] ^ 8'h3c);
        walk();
        check(pwrC, model[4]);
        check(tmrC, model[5]);
        check(tmrM, model[6]);
        check({p1S, p3S}, {model[12][7:4], model[13][7:6]});
        check(p4S, model[14]);
        check(cPre, model[15]);
        check(cCtl, model[17]);
        check({s1C, s1B}, {model[18], model[19]});
        check({s2C, s2B}, {model[20], model[21]});
        check({pwC, pwD0, pwD1}, {model[23], model[24], model[25]});
        check({port0Out, port1Out}, {model[0], model[11]});
        check({port2Out, stackOut}, {model[22], model[1]});
        check(dptr, {model[3], model[2]});
    endtask

    task t_unmapped;
        logic [7:0] holes [10];
        holes = '{8'h84, 8'h85, 8'h86, 8'h8e, 8'h8f, 8'h92,
            8'h9c, 8'h9f, 8'ha4, 8'hff};
        foreach (holes[i]) bus(1'b1, {1'b0, holes[i]}, 8'hff, 4'h1);
        bus(1'b1, 9'h085, 8'h00, 4'h1);
        bus(1'b1, 9'h081, 8'hee, 4'h0);
        walk();
    endtask

    // Single-bit window: writes on the port 1 and timer control rows, a read on the port 0 row
    task t_bits;
        bus(1'b1, {1'b1, 5'h12, 3'd3}, 8'h00, 4'h1);
        model[special_function_pkg::IDX_PORT1][3] = 1'b0;
        bus(1'b1, {1'b1, 5'h11, 3'd6}, 8'h01, 4'h1);
        model[special_function_pkg::IDX_TIMER_CTRL][6] = 1'b1;
        walk();
        bus(1'b0, {1'b1, 5'h10, 3'd0}, 8'h00, 4'h1);
        check(q, {31'h0, model[special_function_pkg::IDX_PORT0][0]});
        check(port1Out, model[special_function_pkg::IDX_PORT1]);
    endtask

    // Hardware events in back-to-back cycles set flags and load data
    task t_events;
        wr(8'h88, 8'h00);
        wr(8'h97, 8'h00);
        wr(8'h98, 8'h00);
        wr(8'h9a, 8'h00);
        @(posedge mclk);
        {t0Ov, cDone, s1Rx, s2Tx} <= 4'hf;
        cRes <= 8'ha5;
        s1Data <= 9'h1c3;
        @(posedge mclk);
        {t0Ov, cDone, s1Rx, s2Tx} <= 4'h0;
        {t1Ov, e0, e1, s1Tx, s2Rx} <= 5'h1f;
        s2Data <= 9'h05a;
        @(posedge mclk);
        {t1Ov, e0, e1, s1Tx, s2Rx} <= 5'h00;
        cRes <= 8'h5a;
        s1Data <= 9'h03c;
        s2Data <= 9'h1a5;
        @(posedge mclk);
        check(tmrC, 8'haa);
        check(cCtl, 8'h01);
        check({s1C, s2C}, 16'h0703);
        bus(1'b0, 9'h096, 8'h00, 4'h1);
        check(q, 32'ha5);
        bus(1'b0, 9'h099, 8'h00, 4'h1);
        check(q, 32'hc3);
        bus(1'b0, 9'h09b, 8'h00, 4'h1);
        check(q, 32'h5a);
    endtask

    initial begin
        rst_n = 1'b0;
        {t0Ov, t1Ov, e0, e1, cDone, s1Tx, s1Rx, s2Tx, s2Rx} = 9'h000;
        cRes = 8'h00;
        s1Data = 9'h000;
        s2Data = 9'h000;
        do_reset();
        t_reset();
        t_rw();
        t_unmapped();
        t_bits();
        t_events();
        do_reset();
        t_reset();
        wrap_up();
    end
endmodule

`default_nettype wire
